// [hw/tfp_ctrl.sv]
// controller end: apb slave that runs byte and 10-bit accesses
// assumes one apb master on mclk; device answers reads next cycle
`include "tfp_params.svh"
`default_nettype none
module tfp_ctrl (
	tfp_if.ctl          bus,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	tfp_pkg::tfp_state_t state_reg;
	logic [3:0] addr_reg;
	logic [7:0] lo_reg;
	logic [1:0] hi_reg;
	logic       write_reg;
	logic       wide_reg;
	logic [9:0] result_reg;
	logic [3:0] settle_reg;
	logic       bwr_reg;
	logic       brd_reg;
	logic [3:0] baddr_reg;
	logic [7:0] bdata_reg;
	logic       start;
	logic       is_ctrl;

	assign start   = psel && penable && pwrite && paddr == `TFP_APB_CMD && state_reg == tfp_pkg::TFP_IDLE;
	assign is_ctrl = write_reg && addr_reg == `TFP_A_CTRL_D;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// ==========================================================
	// access sequencer
	// ==========================================================
	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			state_reg  <= tfp_pkg::TFP_IDLE;
			addr_reg   <= 4'h0;
			lo_reg     <= 8'h00;
			hi_reg     <= 2'h0;
			write_reg  <= 1'b0;
			wide_reg   <= 1'b0;
			result_reg <= 10'h000;
			settle_reg <= 4'h0;
			bwr_reg    <= 1'b0;
			brd_reg    <= 1'b0;
			baddr_reg  <= 4'h0;
			bdata_reg  <= 8'h00;
		end else begin
			bwr_reg <= 1'b0;
			brd_reg <= 1'b0;
			case (state_reg)
				tfp_pkg::TFP_IDLE: begin
					if (start) begin
						addr_reg  <= pwdata[3:0];
						lo_reg    <= pwdata[15:8];
						hi_reg    <= pwdata[17:16];
						write_reg <= pwdata[`TFP_CMD_WRITE];
						wide_reg  <= pwdata[`TFP_CMD_WIDE];
						bwr_reg   <= pwdata[`TFP_CMD_WRITE];
						brd_reg   <= ~pwdata[`TFP_CMD_WRITE];
						// wide write puts the temp first, wide read the low byte
						if (pwdata[`TFP_CMD_WIDE] && pwdata[`TFP_CMD_WRITE]) begin
							baddr_reg <= `TFP_A_HIGH_TEMP;
							bdata_reg <= {6'h00, pwdata[17:16]};
						end else begin
							baddr_reg <= pwdata[3:0];
							bdata_reg <= pwdata[15:8]; // narrow write reuses the temp
						end
						state_reg <= tfp_pkg::TFP_OP1;
					end
				end
				tfp_pkg::TFP_OP1: begin
					state_reg <= tfp_pkg::TFP_GAP1;
				end
				tfp_pkg::TFP_GAP1: begin
					if (!write_reg) begin
						// narrow reads leave no stale high bits behind
						result_reg <= {2'h0, bus.bus_rdata};
					end
					if (wide_reg) begin
						// second step follows at once, nothing can slip between
						bwr_reg   <= write_reg;
						brd_reg   <= ~write_reg;
						baddr_reg <= write_reg ? addr_reg : `TFP_A_HIGH_TEMP;
						bdata_reg <= lo_reg;
						state_reg <= tfp_pkg::TFP_OP2;
					end else if (is_ctrl) begin
						settle_reg <= `TFP_SETTLE_CYC;
						state_reg  <= tfp_pkg::TFP_SETTLE;
					end else begin
						state_reg <= tfp_pkg::TFP_IDLE;
					end
				end
				tfp_pkg::TFP_OP2: begin
					state_reg <= tfp_pkg::TFP_GAP2;
				end
				tfp_pkg::TFP_GAP2: begin
					if (!write_reg) begin
						result_reg[9:8] <= bus.bus_rdata[1:0];
					end
					state_reg <= tfp_pkg::TFP_IDLE;
				end
				tfp_pkg::TFP_SETTLE: begin
					// let a source change reach the edge detector first
					if (settle_reg == 4'h0) begin
						bwr_reg   <= 1'b1;
						baddr_reg <= `TFP_A_CTRL_D;
						bdata_reg <= lo_reg | 8'(1 << `TFP_B_FLAG);
						state_reg <= tfp_pkg::TFP_CLR;
					end else begin
						settle_reg <= settle_reg - 4'h1;
					end
				end
				tfp_pkg::TFP_CLR: begin
					state_reg <= tfp_pkg::TFP_IDLE;
				end
				default: begin
					state_reg <= tfp_pkg::TFP_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// apb read data
	// ==========================================================
	always_comb begin
		if (paddr == `TFP_APB_STATUS) begin
			prdata = {6'h00, result_reg, 14'h0000, bus.fault_irq, state_reg != tfp_pkg::TFP_IDLE};
		end else begin
			prdata = 32'h0000_0000;
		end
	end

	assign bus.bus_wr    = bwr_reg;
	assign bus.bus_rd    = brd_reg;
	assign bus.bus_addr  = baddr_reg;
	assign bus.bus_wdata = bdata_reg;
endmodule : tfp_ctrl
`default_nettype wire

// [hw/tfp_device.sv]
// timer fault protection unit with shared high-byte 10-bit access
// assumes a byte bus whose strobes last one cycle, pads from outside
`include "tfp_params.svh"
`default_nettype none
module tfp_device (
	tfp_if.dev        bus,
	input  wire logic timer_tick_enable,
	input  wire logic comparator_output,
	output logic [3:0] pwm_pins
);
	// ==========================================================
	// registers
	// ==========================================================
	logic [9:0] count_reg;
	logic [9:0] cmp_reg [0:3];
	logic [1:0] temp_reg;
	logic       filter_en_reg;
	logic       cmp_sel_reg;
	logic       irq_en_reg;
	logic       arm_reg;
	logic       flag_reg;
	logic       irq_reg;
	logic [7:0] com_reg;
	logic [7:0] port_reg;
	logic       dir_reg;
	logic [7:0] rdata_reg;
	logic       fault_edge;
	logic       wr_ctrl;
	logic       flag_clr;
	logic       wr_lo;
	logic       rd_lo;
	logic [2:0] lo_idx;
	logic [9:0] lo_value;

	assign wr_ctrl  = bus.bus_wr && (bus.bus_addr == `TFP_A_CTRL_D);
	assign flag_clr = wr_ctrl && bus.bus_wdata[`TFP_B_FLAG];
	assign lo_idx   = bus.bus_addr[2:0];
	assign wr_lo    = bus.bus_wr && (bus.bus_addr <= `TFP_A_CMPD_LO);
	assign rd_lo    = bus.bus_rd && (bus.bus_addr <= `TFP_A_CMPD_LO);

	always_comb begin
		if (lo_idx == 3'h0) begin
			lo_value = count_reg;
		end else begin
			lo_value = cmp_reg[lo_idx[1:0] - 2'h1];
		end
	end

	// ==========================================================
	// input path: synchronise, select, filter, detect
	// ==========================================================
	logic [1:0] pin_sync_reg;
	logic [1:0] cmp_sync_reg;
	logic [3:0] filt_pipe_reg;
	logic       filt_hold_reg;
	logic       filt_out;
	logic       edge_prev_reg;
	logic       src_level;
	logic       det_level;

	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			pin_sync_reg <= 2'h0;
			cmp_sync_reg <= 2'h0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[0], bus.ext_irq_pin_zero};
			cmp_sync_reg <= {cmp_sync_reg[0], comparator_output};
		end
	end

	assign src_level = cmp_sel_reg ? cmp_sync_reg[1] : pin_sync_reg[1];

	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			filt_pipe_reg <= 4'h0;
			filt_hold_reg <= 1'b0;
		end else begin
			// runs every cycle, regardless of the tick
			filt_pipe_reg <= {filt_pipe_reg[2:0], src_level};
			filt_hold_reg <= filt_out;
		end
	end

	// decided straight from the pipe so the filter costs four cycles, not five
	always_comb begin
		if (filt_pipe_reg == 4'hF) begin
			filt_out = 1'b1;
		end else if (filt_pipe_reg == 4'h0) begin
			filt_out = 1'b0;
		end else begin
			filt_out = filt_hold_reg;
		end
	end

	assign det_level = filter_en_reg ? filt_out : src_level;

	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			edge_prev_reg <= 1'b0;
		end else begin
			edge_prev_reg <= det_level;
		end
	end

	assign fault_edge = det_level != edge_prev_reg;

	// ==========================================================
	// fault protection control
	// ==========================================================
	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			filter_en_reg <= 1'b0;
			cmp_sel_reg   <= 1'b0;
			irq_en_reg    <= 1'b0;
			arm_reg       <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				filter_en_reg <= bus.bus_wdata[`TFP_B_FILTER_EN];
				cmp_sel_reg   <= bus.bus_wdata[`TFP_B_CMP_SEL];
				irq_en_reg    <= bus.bus_wdata[`TFP_B_IRQ_EN];
			end
			if (fault_edge && arm_reg) begin
				arm_reg <= 1'b0;
			end else if (wr_ctrl) begin
				arm_reg <= bus.bus_wdata[`TFP_B_ARM];
			end
		end
	end

	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			flag_reg <= 1'b0;
			irq_reg  <= 1'b0;
		end else begin
			// a new edge wins over a clear in the same cycle
			if (fault_edge) begin
				flag_reg <= 1'b1;
			end else if (flag_clr) begin
				flag_reg <= 1'b0;
			end
			if (fault_edge && arm_reg && irq_en_reg) begin
				irq_reg <= 1'b1;
			end else if (flag_clr) begin
				irq_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			com_reg  <= 8'h00;
			port_reg <= 8'h00;
			dir_reg  <= 1'b0;
		end else begin
			if (fault_edge && arm_reg) begin
				com_reg <= 8'h00;
			end else if (bus.bus_wr && bus.bus_addr == `TFP_A_COM_MODE) begin
				com_reg <= bus.bus_wdata;
			end
			if (bus.bus_wr && bus.bus_addr == `TFP_A_PORT_B) begin
				port_reg <= bus.bus_wdata;
			end
			if (bus.bus_wr && bus.bus_addr == `TFP_A_PIN_DIR) begin
				dir_reg <= bus.bus_wdata[0];
			end
		end
	end

	// ==========================================================
	// counter, compares and the shared temp
	// ==========================================================
	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			count_reg <= 10'h000;
		end else if (wr_lo && lo_idx == 3'h0) begin
			count_reg <= {temp_reg, bus.bus_wdata};
		end else if (timer_tick_enable) begin
			count_reg <= count_reg + 10'h001;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
			always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
				if (!bus.arst_n) begin
					cmp_reg[gi] <= 10'h000;
				end else if (wr_lo && lo_idx == 3'(gi + 1)) begin
					cmp_reg[gi] <= {temp_reg, bus.bus_wdata};
				end
			end
			// compare output while either of its mode bits is set, else port bit
			always_comb begin
				if (com_reg[2*gi +: 2] != 2'h0) begin
					pwm_pins[gi] = count_reg < cmp_reg[gi];
				end else begin
					pwm_pins[gi] = port_reg[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			temp_reg <= 2'h0;
		end else if (rd_lo) begin
			temp_reg <= lo_value[9:8];
		end else if (bus.bus_wr && bus.bus_addr == `TFP_A_HIGH_TEMP) begin
			temp_reg <= bus.bus_wdata[1:0];
		end
	end

	// ==========================================================
	// read data, one cycle after the strobe
	// ==========================================================
	always_ff @(posedge bus.mclk or negedge bus.arst_n) begin
		if (!bus.arst_n) begin
			rdata_reg <= 8'h00;
		end else if (bus.bus_rd) begin
			if (rd_lo) begin
				rdata_reg <= lo_value[7:0];
			end else if (bus.bus_addr == `TFP_A_HIGH_TEMP) begin
				rdata_reg <= {6'h00, temp_reg};
			end else if (bus.bus_addr == `TFP_A_CTRL_D) begin
				rdata_reg <= {3'h0, flag_reg, arm_reg, irq_en_reg, cmp_sel_reg, filter_en_reg};
			end else if (bus.bus_addr == `TFP_A_COM_MODE) begin
				rdata_reg <= com_reg;
			end else if (bus.bus_addr == `TFP_A_PORT_B) begin
				rdata_reg <= port_reg;
			end else if (bus.bus_addr == `TFP_A_PIN_DIR) begin
				rdata_reg <= {7'h00, dir_reg};
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end

	assign bus.bus_rdata    = rdata_reg;
	assign bus.fault_irq    = irq_reg;
	assign bus.irq_pin_o    = port_reg[`TFP_B_PORT_IRQ];
	assign bus.irq_pin_oe_n = ~dir_reg;
endmodule : tfp_device
`default_nettype wire

// [hw/tfp_if.sv]
// byte bus and pins between the timer device and its controller
// assumes the bench drives ext_irq_drive and joins both ends
`default_nettype none
interface tfp_if (
	input wire logic mclk,
	input wire logic arst_n
);
	logic [3:0] bus_addr;
	logic [7:0] bus_wdata;
	logic       bus_wr;
	logic       bus_rd;
	logic [7:0] bus_rdata;
	logic       fault_irq;
	logic       irq_pin_o;
	logic       irq_pin_oe_n;
	logic       ext_irq_drive;
	logic       ext_irq_pin_zero;
	// pad level: device drives when enabled, else the outside level
	assign ext_irq_pin_zero = irq_pin_oe_n ? ext_irq_drive : irq_pin_o;
	modport dev (
		input  mclk, arst_n, bus_addr, bus_wdata, bus_wr, bus_rd, ext_irq_pin_zero,
		output bus_rdata, fault_irq, irq_pin_o, irq_pin_oe_n
	);
	modport ctl (
		input  mclk, arst_n, bus_rdata, fault_irq,
		output bus_addr, bus_wdata, bus_wr, bus_rd
	);
endinterface : tfp_if
`default_nettype wire

// [hw/tfp_params.svh]
// constants of the fault protection and 10-bit access block
// assumes a single 20 MHz mclk domain on both ends
`ifndef TFP_PARAMS_SVH
`define TFP_PARAMS_SVH
// device register addresses on the 8-bit bus
`define TFP_A_COUNT_LO   4'h0
`define TFP_A_CMPA_LO    4'h1
`define TFP_A_CMPB_LO    4'h2
`define TFP_A_CMPC_LO    4'h3
`define TFP_A_CMPD_LO    4'h4
`define TFP_A_HIGH_TEMP  4'h5
`define TFP_A_CTRL_D     4'h6
`define TFP_A_COM_MODE   4'h7
`define TFP_A_PORT_B     4'h8
`define TFP_A_PIN_DIR    4'h9
// control register d bit positions
`define TFP_B_FILTER_EN  0
`define TFP_B_CMP_SEL    1
`define TFP_B_IRQ_EN     2
`define TFP_B_ARM        3
`define TFP_B_FLAG       4
// port b bit that drives the external interrupt pad
`define TFP_B_PORT_IRQ   7
`define TFP_FILTER_DEPTH 4
// controller apb map
`define TFP_APB_CMD      8'h00
`define TFP_APB_STATUS   8'h04
`define TFP_CMD_WRITE    24
`define TFP_CMD_WIDE     25
// wait after a control d write before clearing the flag
`define TFP_SETTLE_CYC   4'hA
`endif

// [hw/tfp_pkg.sv]
// types used by the controller end of the fault protection block
// assumes tfp_params.svh for the numbers
`default_nettype none
package tfp_pkg;
	typedef enum logic [2:0] {
		TFP_IDLE   = 3'b000,
		TFP_OP1    = 3'b001,
		TFP_GAP1   = 3'b010,
		TFP_OP2    = 3'b011,
		TFP_GAP2   = 3'b100,
		TFP_SETTLE = 3'b101,
		TFP_CLR    = 3'b110
	} tfp_state_t;
endpackage : tfp_pkg
`default_nettype wire

// [sim/tfp_chk.sv]
// checker of the byte bus and pad joining device and controller
// assumes the bench feeds it the signals of the shared tfp_if
`default_nettype none
module tfp_chk (
	input wire logic       mclk,
	input wire logic       arst_n,
	input wire logic [3:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic       fault_irq,
	input wire logic       irq_pin_o,
	input wire logic       irq_pin_oe_n,
	input wire logic       ext_irq_pin_zero
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ==========================================
	// byte bus
	one_strobe_a: assert property (!(bus_wr && bus_rd))
		else $error("read and write strobes together");
	wr_pulse_a: assert property (bus_wr |=> !bus_wr)
		else $error("write strobe longer than one cycle");
	rd_pulse_a: assert property (bus_rd |=> !bus_rd)
		else $error("read strobe longer than one cycle");
	rdata_hold_a: assert property (!$stable(bus_rdata) |-> $past(bus_rd))
		else $error("read byte changed without a read");
	// ==========================================
	// pad and interrupt
	pin_drive_a: assert property (bus_wr && bus_addr == 4'h8 |=> irq_pin_o == $past(bus_wdata[7]))
		else $error("pad drive value not taken from port write");
	pin_hold_a: assert property (!$stable(irq_pin_o) |-> $past(bus_wr && bus_addr == 4'h8))
		else $error("pad drive value changed without port write");
	pin_dir_a: assert property (bus_wr && bus_addr == 4'h9 |=> irq_pin_oe_n == !$past(bus_wdata[0]))
		else $error("pad enable not taken from direction write");
	pad_level_a: assert property (!irq_pin_oe_n |-> ext_irq_pin_zero == irq_pin_o)
		else $error("driven pad level differs from drive value");
	irq_clear_a: assert property ($fell(fault_irq) |-> $past(bus_wr && bus_addr == 4'h6 && bus_wdata[4]))
		else $error("fault request dropped without flag clear");
endmodule : tfp_chk
`default_nettype wire

// [sim/timer_fault_protect_wide_access_bench.sv]
// bench joining device and controller, driven through apb
// assumes zero-wait apb and the map of tfp_params.svh
`default_nettype none
module timer_fault_protect_wide_access_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        comp = 1'b0;
	logic        tick = 1'b0;
	logic [3:0]  pwm_pins;
	logic [31:0] st;
	logic [9:0]  res;
	int          n1;
	int          n2;
	int          error_cnt = 0;
	int          num_checks = 0;
	always #25 mclk = ~mclk;
	tfp_if bus_if (.mclk(mclk), .arst_n(arst_n));
	tfp_device tfp_device_inst (.bus(bus_if), .timer_tick_enable(tick), .comparator_output(comp),
		.pwm_pins(pwm_pins));
	tfp_ctrl tfp_ctrl_inst (.bus(bus_if), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	tfp_chk tfp_chk_inst (.mclk(mclk), .arst_n(arst_n), .bus_addr(bus_if.bus_addr),
		.bus_wdata(bus_if.bus_wdata), .bus_wr(bus_if.bus_wr), .bus_rd(bus_if.bus_rd),
		.bus_rdata(bus_if.bus_rdata), .fault_irq(bus_if.fault_irq), .irq_pin_o(bus_if.irq_pin_o),
		.irq_pin_oe_n(bus_if.irq_pin_oe_n), .ext_irq_pin_zero(bus_if.ext_irq_pin_zero));
	initial bus_if.ext_irq_drive = 1'b0;
	// ==========================================
	// tasks
	task automatic chk(input logic [9:0] seen, input logic [9:0] want);
		num_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		logic r;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			r = pready;
			q = prdata;
		end while (r !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// device access through the controller, result left in res
	task automatic cmd(input logic [3:0] a, input logic [9:0] v, input logic w, input logic wd);
		logic [31:0] q;
		apb(1'b1, 8'h00, {6'h00, wd, w, 6'h00, v[9:8], v[7:0], 4'h0, a}, q);
		do
			apb(1'b0, 8'h04, 32'h00000000, st);
		while (st[0] !== 1'b0);
		res = st[25:16];
	endtask : cmd
	task automatic pad(input logic v);
		@(posedge mclk);
		bus_if.ext_irq_drive <= v;
		repeat (20) @(posedge mclk);
	endtask : pad
	// cycles from a comparator change until the pins fall back to port bits
	task automatic lat(output int n);
		@(posedge mclk);
		comp <= ~comp;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (pwm_pins !== 4'h5 && n < 40);
	endtask : lat
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	// ==========================================
	// tests
	initial begin
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		cmd(4'h1, 10'h2A5, 1'b1, 1'b1);
		cmd(4'h1, 10'h000, 1'b0, 1'b1);
		chk(res, 10'h2A5);
		cmd(4'h5, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h002);
		cmd(4'h2, 10'h1C3, 1'b1, 1'b1);
		cmd(4'h3, 10'h077, 1'b1, 1'b0);
		cmd(4'h3, 10'h000, 1'b0, 1'b1);
		chk(res, 10'h177);
		cmd(4'h2, 10'h000, 1'b0, 1'b1);
		chk(res, 10'h1C3);
		cmd(4'h0, 10'h3FE, 1'b1, 1'b1);
		cmd(4'h0, 10'h000, 1'b0, 1'b1);
		chk(res, 10'h3FE);
		// one cycle of tick advances the counter by one
		@(posedge mclk);
		tick <= 1'b1;
		@(posedge mclk);
		tick <= 1'b0;
		cmd(4'h0, 10'h000, 1'b0, 1'b1);
		chk(res, 10'h3FF);
		cmd(4'hF, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h000);
		apb(1'b0, 8'h10, 32'h00000000, st);
		chk(st[9:0], 10'h000);
		// pin fault, armed with request
		cmd(4'h8, 10'h005, 1'b1, 1'b0);
		cmd(4'h7, 10'h0FF, 1'b1, 1'b0);
		cmd(4'h6, 10'h00C, 1'b1, 1'b0);
		chk({6'h00, pwm_pins}, 10'h000);
		pad(1'b1);
		cmd(4'h6, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h014);
		chk({9'h000, st[1]}, 10'h001);
		cmd(4'h7, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h000);
		chk({6'h00, pwm_pins}, 10'h005);
		// pin edge while disarmed only sets the flag
		cmd(4'h6, 10'h010, 1'b1, 1'b0);
		cmd(4'h7, 10'h0FF, 1'b1, 1'b0);
		pad(1'b0);
		cmd(4'h6, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h010);
		chk({9'h000, st[1]}, 10'h000);
		cmd(4'h7, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h0FF);
		// comparator source with filter
		cmd(4'h6, 10'h00B, 1'b1, 1'b0);
		pad(1'b1);
		cmd(4'h6, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h00B);
		@(posedge mclk);
		comp <= 1'b1;
		repeat (2) @(posedge mclk);
		comp <= 1'b0;
		repeat (20) @(posedge mclk);
		cmd(4'h6, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h00B);
		lat(n2);
		cmd(4'h7, 10'h0FF, 1'b1, 1'b0);
		cmd(4'h6, 10'h00A, 1'b1, 1'b0);
		lat(n1);
		chk(10'(n2 - n1), 10'h004);
		cmd(4'h6, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h012);
		// software trigger through the port bit
		cmd(4'h6, 10'h010, 1'b1, 1'b0);
		cmd(4'h8, 10'h085, 1'b1, 1'b0);
		cmd(4'h9, 10'h001, 1'b1, 1'b0);
		cmd(4'h6, 10'h008, 1'b1, 1'b0);
		cmd(4'h8, 10'h005, 1'b1, 1'b0);
		repeat (20) @(posedge mclk);
		cmd(4'h6, 10'h000, 1'b0, 1'b0);
		chk(res, 10'h010);
		close_out();
	end
	initial begin
		repeat (30000) @(posedge mclk);
		error_cnt++;
		close_out();
	end
endmodule : timer_fault_protect_wide_access_bench
`default_nettype wire
